// File: core/mar_pkg.sv
// shared constants for the measurement archive ring buffer
package mar_pkg;
  localparam int unsigned REC_BYTES = 8;
  localparam int unsigned RECS_PER_PAGE = 66;
  localparam int unsigned PAGE_BYTES = 528;
  localparam int unsigned PAGES = 8192;
  localparam int unsigned PRIMARY_PAGES = 8096;
  localparam logic [15:0] OFS_VALUE_SELECT = 16'h0fe0;
  localparam logic [15:0] OFS_TRIGGER_SOURCE = 16'h0fe1;
  localparam logic [15:0] OFS_MODE_SELECT = 16'h0fe2;
  localparam logic [15:0] OFS_PERIOD = 16'h0fe3;
  localparam logic [15:0] OFS_ERASE_REQUEST = 16'h0fe4;
  localparam logic [15:0] OFS_CARD_COPY = 16'h0fe5;
  localparam logic [15:0] OFS_PAGE_SELECT = 16'h1194;
  localparam logic [15:0] OFS_RECORD_BASE = 16'h1195;
  localparam logic [15:0] OFS_RECORD_WORDS = 16'h0108;
  localparam logic [15:0] OFS_LOWER_THRESHOLD = 16'h1db8;
  localparam logic [15:0] OFS_UPPER_THRESHOLD = 16'h1db9;
  localparam logic [15:0] OFS_CARD_USAGE = 16'h1dbe;
  localparam logic [15:0] RST_PERIOD = 16'h0001;
  localparam logic [11:0] YEAR_BASE = 12'h7da;
  localparam int unsigned TS_YEAR_POS = 26;
  localparam int unsigned TS_MONTH_POS = 22;
  localparam int unsigned TS_DAY_POS = 17;
  localparam int unsigned TS_HOUR_POS = 12;
  localparam int unsigned TS_MINUTE_POS = 6;
  localparam int unsigned TS_SECOND_POS = 0;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam logic [2:0] VSEL_SECOND_BIT = 3'h0;
  typedef enum {
    MAR_H_OFF,
    MAR_H_ON,
    MAR_C_ON,
    MAR_C_OFF,
    MAR_N_ON,
    MAR_N_OFF
  } mar_mode_t;
endpackage

// File: core/mar_archive.sv
// archive ring buffer: record fifo, paged store, pointers and register port
`timescale 1ns/1ps
`default_nettype none

module mar_fifo #(
  parameter int unsigned W = 64,
  parameter int unsigned D = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int unsigned AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  logic push;
  logic pop;
  assign in_ready = (cnt != (AW+1)'(D));
  assign out_valid = (cnt != '0);
  assign out_data = mem[rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wp] <= in_data;
    end
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end
    else
    begin
      if (push)
      begin
        wp <= (wp == AW'(D-1)) ? '0 : wp + 1'b1;
      end
      if (pop)
      begin
        rp <= (rp == AW'(D-1)) ? '0 : rp + 1'b1;
      end
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // mar_fifo

// Contract
// - the primary area holds at most 534336 records
// - when full, each new record replaces the oldest one
// - store is 8192 pages of 528 bytes, addressed by page
// - each page holds 66 records of 8 bytes from byte zero
// - pages below 8096 are primary; the top 96 pages are reserve
// - begin pointer is page plus byte of the oldest record
// - end pointer is newest page plus byte of the next write
// - erase copies end into begin and leaves stored bytes alone
// - a record is a 4-byte timestamp then a 4-byte float
// - timestamp packs year-2010, month, day, hour, minute, second from the top
// - occupancy is reported as one of eight 12.5 percent levels
// - page select, then record n sits at registers 4501+4n..4504+4n
// - changing the value selection erases the archive
// - primary value always archived; second value when selected
// - modes: continuous on/off plus four threshold-gated options
// - conditional modes compare trigger against lower and upper thresholds
// - archive settings are writable over the register port
module mar_archive #(
  parameter int unsigned PAGES = mar_pkg::PAGES,
  parameter int unsigned PRIMARY_PAGES = mar_pkg::PRIMARY_PAGES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sec_tick,
  input wire logic [31:0] primary_value,
  input wire logic [31:0] second_value,
  input wire logic [11:0] rtc_year,
  input wire logic [3:0] rtc_month,
  input wire logic [4:0] rtc_day,
  input wire logic [4:0] rtc_hour,
  input wire logic [5:0] rtc_minute,
  input wire logic [5:0] rtc_second,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  output logic [2:0] usage_level,
  output logic archiving_active,
  output logic [12:0] begin_page,
  output logic [9:0] begin_byte,
  output logic [12:0] end_page,
  output logic [9:0] end_byte
);
  localparam int unsigned RPP = mar_pkg::RECS_PER_PAGE;
  localparam int unsigned CAP = PRIMARY_PAGES * RPP;
  localparam int unsigned IW = $clog2(PAGES * RPP);
  localparam logic [9:0] LAST_BYTE = 10'(mar_pkg::PAGE_BYTES - mar_pkg::REC_BYTES);
  localparam logic [9:0] STEP = 10'(mar_pkg::REC_BYTES);
  localparam logic [12:0] LAST_PAGE = 13'(PRIMARY_PAGES - 1);

  logic [63:0] store [PAGES * RPP];
  logic [15:0] value_select;
  logic [15:0] trigger_source;
  logic [15:0] mode_select;
  logic [15:0] period;
  logic [15:0] card_copy;
  logic [15:0] page_select;
  logic [31:0] lower_threshold;
  logic [31:0] upper_threshold;
  logic [31:0] card_usage;
  logic [15:0] period_cnt;
  logic [IW:0] count;
  logic second_pending;
  logic [63:0] second_rec;

  // float ordering key: flips negatives so unsigned compare follows value
  function automatic logic [31:0] fkey(input logic [31:0] f);
    fkey = f[31] ? ~f : (f | 32'h80000000);
  endfunction

  logic wr_sel;
  logic erase_go;
  logic [31:0] trig;
  logic above;
  logic below;
  logic sample;
  logic [31:0] ts;
  logic f_in_valid;
  logic f_in_ready;
  logic [63:0] f_in_data;
  logic f_out_valid;
  logic f_out_ready;
  logic [63:0] f_out_data;
  logic wr_go;
  logic [15:0] rd_off;
  logic rd_rec;
  logic [IW-1:0] rd_idx;
  logic [IW-1:0] wr_idx;
  logic [63:0] rd_word;

  assign wr_sel = reg_wr && (reg_addr == mar_pkg::OFS_VALUE_SELECT);
  // erase on request or on a change of the value selection
  assign erase_go = (reg_wr && reg_addr == mar_pkg::OFS_ERASE_REQUEST && reg_wdata[15:0] != '0)
    || (wr_sel && reg_wdata[15:0] != value_select);

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      value_select <= '0;
      trigger_source <= '0;
      mode_select <= '0;
      period <= mar_pkg::RST_PERIOD;
      card_copy <= '0;
      page_select <= '0;
      lower_threshold <= '0;
      upper_threshold <= '0;
      card_usage <= '0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        mar_pkg::OFS_VALUE_SELECT: value_select <= reg_wdata[15:0];
        mar_pkg::OFS_TRIGGER_SOURCE: trigger_source <= reg_wdata[15:0];
        mar_pkg::OFS_MODE_SELECT: mode_select <= reg_wdata[15:0];
        mar_pkg::OFS_PERIOD: period <= reg_wdata[15:0];
        mar_pkg::OFS_CARD_COPY: card_copy <= reg_wdata[15:0];
        mar_pkg::OFS_PAGE_SELECT: page_select <= reg_wdata[15:0];
        mar_pkg::OFS_LOWER_THRESHOLD: lower_threshold <= reg_wdata;
        mar_pkg::OFS_UPPER_THRESHOLD: upper_threshold <= reg_wdata;
        mar_pkg::OFS_CARD_USAGE: card_usage <= reg_wdata;
        default:
        begin
        end
      endcase
    end
  end

  // threshold gating of the trigger value
  assign trig = (trigger_source != '0) ? second_value : primary_value;
  assign above = fkey(trig) > fkey(upper_threshold);
  assign below = fkey(trig) < fkey(lower_threshold);

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      archiving_active <= 1'b0;
    end
    else
    begin
      case (mode_select[2:0])
        3'(mar_pkg::MAR_H_OFF): archiving_active <= 1'b0;
        3'(mar_pkg::MAR_H_ON): archiving_active <= 1'b1;
        3'(mar_pkg::MAR_C_ON):
        begin
          if (above)
          begin
            archiving_active <= 1'b1;
          end
          else if (below)
          begin
            archiving_active <= 1'b0;
          end
        end
        3'(mar_pkg::MAR_C_OFF):
        begin
          if (below)
          begin
            archiving_active <= 1'b1;
          end
          else if (above)
          begin
            archiving_active <= 1'b0;
          end
        end
        3'(mar_pkg::MAR_N_ON): archiving_active <= !above && !below;
        3'(mar_pkg::MAR_N_OFF): archiving_active <= above || below;
        default: archiving_active <= 1'b0;
      endcase
    end
  end

  // archive period counted in seconds
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      period_cnt <= '0;
    end
    else if (sec_tick)
    begin
      period_cnt <= (period_cnt + 16'h0001 >= period) ? '0 : period_cnt + 16'h0001;
    end
  end
  assign sample = sec_tick && archiving_active && (period_cnt + 16'h0001 >= period);

  assign ts = {6'(rtc_year - mar_pkg::YEAR_BASE), rtc_month, rtc_day,
    rtc_hour, rtc_minute, rtc_second};

  // primary record first, second value one cycle later when selected
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      second_pending <= 1'b0;
      second_rec <= '0;
    end
    else if (second_pending)
    begin
      second_pending <= !f_in_ready;
    end
    else if (sample && f_in_ready && value_select[mar_pkg::VSEL_SECOND_BIT])
    begin
      second_pending <= 1'b1;
      second_rec <= {ts, second_value};
    end
  end
  assign f_in_valid = second_pending || sample;
  assign f_in_data = second_pending ? second_rec : {ts, primary_value};

  mar_fifo #(
    .W(64),
    .D(mar_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .rst(rst),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(f_in_data),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  // store port shared with page readout: writer stalls on record reads and erase
  assign rd_off = reg_addr - mar_pkg::OFS_RECORD_BASE;
  assign rd_rec = (reg_addr >= mar_pkg::OFS_RECORD_BASE) && (rd_off < mar_pkg::OFS_RECORD_WORDS);
  assign f_out_ready = !(reg_rd && rd_rec) && !erase_go;
  assign wr_go = f_out_valid && f_out_ready;
  assign rd_idx = IW'(page_select * RPP + rd_off[15:2]);
  assign wr_idx = IW'(end_page * RPP + end_byte[9:3]);
  assign rd_word = store[rd_idx];

  always_ff @(posedge ref_clk)
  begin
    if (wr_go)
    begin
      store[wr_idx] <= f_out_data;
    end
  end

  // pointers: erase leaves store contents, only moves begin
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      begin_page <= '0;
      begin_byte <= '0;
      end_page <= '0;
      end_byte <= '0;
      count <= '0;
    end
    else if (erase_go)
    begin
      begin_page <= end_page;
      begin_byte <= end_byte;
      count <= '0;
    end
    else if (wr_go)
    begin
      if (end_byte == LAST_BYTE)
      begin
        end_byte <= '0;
        end_page <= (end_page == LAST_PAGE) ? '0 : end_page + 13'h0001;
      end
      else
      begin
        end_byte <= end_byte + STEP;
      end
      if (count == (IW+1)'(CAP))
      begin
        if (begin_byte == LAST_BYTE)
        begin
          begin_byte <= '0;
          begin_page <= (begin_page == LAST_PAGE) ? '0 : begin_page + 13'h0001;
        end
        else
        begin
          begin_byte <= begin_byte + STEP;
        end
      end
      else
      begin
        count <= count + 1'b1;
      end
    end
  end

  // occupancy level in eighths
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      usage_level <= '0;
    end
    else
    begin
      usage_level <= '0;
      for (int k = 1; k < 8; k++)
      begin
        if (64'(count) * 64'd8 >= 64'(k) * 64'(CAP))
        begin
          usage_level <= 3'(k);
        end
      end
    end
  end

  // register readback, one cycle after the read strobe
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      reg_rdata <= '0;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      reg_rdata <= '0;
      if (reg_rd && rd_rec)
      begin
        case (rd_off[1:0])
          2'h0: reg_rdata <= {16'h0000, rd_word[63:48]};
          2'h1: reg_rdata <= {16'h0000, rd_word[47:32]};
          2'h2: reg_rdata <= {16'h0000, rd_word[31:16]};
          default: reg_rdata <= {16'h0000, rd_word[15:0]};
        endcase
      end
      else if (reg_rd)
      begin
        case (reg_addr)
          mar_pkg::OFS_VALUE_SELECT: reg_rdata <= {16'h0000, value_select};
          mar_pkg::OFS_TRIGGER_SOURCE: reg_rdata <= {16'h0000, trigger_source};
          mar_pkg::OFS_MODE_SELECT: reg_rdata <= {16'h0000, mode_select};
          mar_pkg::OFS_PERIOD: reg_rdata <= {16'h0000, period};
          mar_pkg::OFS_CARD_COPY: reg_rdata <= {16'h0000, card_copy};
          mar_pkg::OFS_PAGE_SELECT: reg_rdata <= {16'h0000, page_select};
          mar_pkg::OFS_LOWER_THRESHOLD: reg_rdata <= lower_threshold;
          mar_pkg::OFS_UPPER_THRESHOLD: reg_rdata <= upper_threshold;
          mar_pkg::OFS_CARD_USAGE: reg_rdata <= card_usage;
          default: reg_rdata <= '0;
        endcase
      end
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_record_read;
    reg_rd && rd_rec;
  endsequence

  a_erase_moves_begin: assert property (erase_go |=>
    begin_page == $past(end_page) && begin_byte == $past(end_byte) && count == '0)
    else $error("erase did not copy end into begin");
  a_end_wraps: assert property (wr_go && end_byte == LAST_BYTE && end_page == LAST_PAGE
    |=> end_page == '0 && end_byte == '0)
    else $error("end pointer failed to wrap at last primary page");
  a_byte_step: assert property (wr_go && end_byte != LAST_BYTE
    |=> end_byte == $past(end_byte) + STEP && end_page == $past(end_page))
    else $error("end byte did not step by one record");
  a_full_overwrite: assert property (wr_go && count == (IW+1)'(CAP)
    |=> count == (IW+1)'(CAP) && (begin_byte != $past(begin_byte)
    || begin_page != $past(begin_page)))
    else $error("full archive did not drop its oldest record");
  a_count_bound: assert property (count <= (IW+1)'(CAP))
    else $error("record count above capacity");
  a_read_latency: assert property (s_record_read |=> reg_rvalid && !$past(f_out_ready))
    else $error("record read did not answer next cycle");
  a_select_erase: assert property (wr_sel && reg_wdata[15:0] != value_select
    ##1 !wr_go |-> count == '0)
    else $error("selection change did not erase");
  a_level_top: assert property (usage_level == 3'h7 |->
    64'($past(count)) * 64'd8 >= 64'd7 * 64'(CAP))
    else $error("usage level seven below its band");
  a_hon_active: assert property (mode_select[2:0] == 3'(mar_pkg::MAR_H_ON)
    ##1 mode_select[2:0] == 3'(mar_pkg::MAR_H_ON) |-> archiving_active)
    else $error("continuous mode not archiving");
  a_ts_pack: assert property (f_in_valid && !second_pending
    |-> f_in_data[63:58] == 6'(rtc_year - mar_pkg::YEAR_BASE)
    && f_in_data[37:32] == rtc_second)
    else $error("timestamp packing wrong");
endmodule // mar_archive

`default_nettype wire

// File: test/mar_host_model.sv
// host model that drives the archive register port
`timescale 1ns/1ps
`default_nettype none

module mar_host_model (
  input wire logic ref_clk,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  output logic [15:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [31:0] reg_wdata
);
  initial
  begin
    reg_addr = 16'hffff;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 32'h0;
  end

  // one strobe per transfer; idle bus shows inverted values so stale data never looks valid
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic ok);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = wr;
    reg_rd = ~wr;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    q = reg_rdata;
    ok = reg_rvalid;
  endtask
endmodule // mar_host_model

`default_nettype wire

// File: test/mar_archive_tb.sv
// self-checking bench for the archive ring buffer and its record fifo
`timescale 1ns/1ps
`default_nettype none

module mar_archive_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic sec_tick = 1'b0;
  logic [31:0] primary_value = 32'h0;
  logic [31:0] second_value = 32'h0999;
  logic [11:0] rtc_year = 12'h7da;
  logic [3:0] rtc_month = 4'h5;
  logic [4:0] rtc_day = 5'h18;
  logic [4:0] rtc_hour = 5'h0b;
  logic [5:0] rtc_minute = 6'h2e;
  logic [5:0] rtc_second = 6'h15;
  logic [15:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic reg_rvalid;
  logic [2:0] usage_level;
  logic archiving_active;
  logic [12:0] begin_page;
  logic [9:0] begin_byte;
  logic [12:0] end_page;
  logic [9:0] end_byte;
  int n_errors = 0;
  int checked = 0;
  logic [15:0] r_addr [13] = '{16'h0fe1, 16'h0fe1, 16'h0fe2, 16'h0fe2, 16'h0fe3, 16'h0fe3,
    16'h0fe5, 16'h1dbe, 16'h1db8, 16'h1db9, 16'h1194, 16'h0fe4, 16'h0fe6};
  logic [31:0] r_data [13] = '{32'h1, 32'h0, 32'h3, 32'h0, 32'h5, 32'h1, 32'h1, 32'h42c7cccd,
    32'h420c0000, 32'h42340000, 32'h2, 32'h1, 32'h1234};
  logic [31:0] r_exp [13] = '{32'h1, 32'h0, 32'h3, 32'h0, 32'h5, 32'h1, 32'h1, 32'h42c7cccd,
    32'h420c0000, 32'h42340000, 32'h2, 32'h0, 32'h0};
  logic [15:0] m_mode [10] = '{16'h4, 16'h4, 16'h5, 16'h2, 16'h2, 16'h2, 16'h3, 16'h3, 16'h3,
    16'h0};
  logic [31:0] m_val [10] = '{32'h42200000, 32'h42480000, 32'h42480000, 32'h42480000,
    32'h42200000, 32'h41f00000, 32'h41f00000, 32'h42200000, 32'h42480000, 32'h42200000};
  logic m_exp [10] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  logic [31:0] ts;

  initial
  begin
    forever #2 ref_clk = ~ref_clk;
  end

  mar_archive #(.PAGES(4), .PRIMARY_PAGES(3)) i_dut (.ref_clk(ref_clk), .rst(rst),
    .sec_tick(sec_tick), .primary_value(primary_value), .second_value(second_value),
    .rtc_year(rtc_year), .rtc_month(rtc_month), .rtc_day(rtc_day), .rtc_hour(rtc_hour),
    .rtc_minute(rtc_minute), .rtc_second(rtc_second), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .usage_level(usage_level), .archiving_active(archiving_active), .begin_page(begin_page),
    .begin_byte(begin_byte), .end_page(end_page), .end_byte(end_byte));

  mar_host_model i_host (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));

  task automatic report_and_stop;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic ok;
    i_host.xfer(1'b1, a, d, q, ok);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic ok;
    i_host.xfer(1'b0, a, 32'h0, q, ok);
    chk({31'h0, ok}, 32'h1);
    chk(q, exp);
  endtask

  task automatic tick(input logic [31:0] v);
    @(posedge ref_clk);
    #1;
    primary_value = v;
    sec_tick = 1'b1;
    @(posedge ref_clk);
    #1;
    sec_tick = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask

  task automatic ptr(input logic [12:0] bp, input logic [9:0] bb, input logic [12:0] ep,
                     input logic [9:0] eb);
    chk({9'h0, begin_page, begin_byte}, {9'h0, bp, bb});
    chk({9'h0, end_page, end_byte}, {9'h0, ep, eb});
  endtask

  initial
  begin
    #100000;
    n_errors++;
    report_and_stop();
  end

  initial
  begin
    repeat (2) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    chk({28'h0, usage_level, archiving_active}, 32'h0);
    ptr(13'h0, 10'h0, 13'h0, 10'h0);
    rd(16'h0fe3, 32'h1);
    rd(16'h0fe0, 32'h0);
    for (int i = 0; i < 13; i++)
    begin
      wr(r_addr[i], r_data[i]);
      rd(r_addr[i], r_exp[i]);
    end
    // 2010-05-24 11:46:21 packed by hand
    ts = 32'h0170bb95;
    wr(16'h0fe2, 32'h1);
    repeat (4) @(posedge ref_clk);
    #1;
    chk({31'h0, archiving_active}, 32'h1);
    tick(32'he87cb942);
    ptr(13'h0, 10'h0, 13'h0, 10'h8);
    wr(16'h1194, 32'h0);
    rd(16'h1195, {16'h0, ts[31:16]});
    rd(16'h1196, {16'h0, ts[15:0]});
    rd(16'h1197, 32'he87c);
    rd(16'h1198, 32'hb942);
    for (int i = 1; i < 303; i++)
    begin
      tick(32'(i));
      chk({31'h0, end_page < 13'h3}, 32'h1);
      if (i == 66)
        ptr(13'h0, 10'h0, 13'h1, 10'h8);
      if (i == 99)
      begin
        chk({29'h0, usage_level}, 32'h4);
        wr(16'h0fe4, 32'h1);
        repeat (3) @(posedge ref_clk);
        #1;
        ptr(13'h1, 10'h110, 13'h1, 10'h110);
        chk({29'h0, usage_level}, 32'h0);
        rd(16'h119c, 32'h1);
      end
    end
    ptr(13'h1, 10'h138, 13'h1, 10'h138);
    chk({29'h0, usage_level}, 32'h7);
    rd(16'h119c, 32'hc7);
    wr(16'h0fe0, 32'h1);
    repeat (3) @(posedge ref_clk);
    #1;
    chk({29'h0, usage_level}, 32'h0);
    tick(32'h0777);
    ptr(13'h1, 10'h138, 13'h1, 10'h148);
    wr(16'h1194, 32'h1);
    rd(16'h1234, 32'h0777);
    rd(16'h1238, 32'h0999);
    for (int i = 0; i < 10; i++)
    begin
      if (i == 0 || m_mode[i] !== m_mode[i - 1])
        wr(16'h0fe2, {16'h0, m_mode[i]});
      @(posedge ref_clk);
      #1;
      primary_value = m_val[i];
      repeat (4) @(posedge ref_clk);
      #1;
      chk({31'h0, archiving_active}, {31'h0, m_exp[i]});
    end
    // samples on eight consecutive cycles pass the record fifo and land in order
    wr(16'h0fe0, 32'h0);
    wr(16'h0fe2, 32'h1);
    @(posedge ref_clk);
    #1;
    sec_tick = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      primary_value = 32'h100 + 32'(i);
      @(posedge ref_clk);
      #1;
    end
    sec_tick = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    ptr(13'h1, 10'h148, 13'h1, 10'h188);
    chk({29'h0, usage_level}, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      rd(16'h123c + 16'(4 * i), 32'h100 + 32'(i));
    end
    chk({31'h0, archiving_active}, 32'h1);
    report_and_stop();
  end
endmodule // mar_archive_tb

`default_nettype wire
